/* verilog/strop_pkg.sv */
package strop_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_SRC_LEN    = 8'h08;
  localparam logic [7:0] OFS_SRC_PTR    = 8'h0c;
  localparam logic [7:0] OFS_DST_LEN    = 8'h10;
  localparam logic [7:0] OFS_DST_PTR    = 8'h14;
  localparam logic [7:0] OFS_FILL       = 8'h18;
  localparam logic [7:0] OFS_OPERAND    = 8'h1c;
  localparam logic [7:0] OFS_BIN_HI     = 8'h20;
  localparam logic [7:0] OFS_BIN_HI_TOP = 8'h24;
  localparam logic [7:0] OFS_BIN_LO     = 8'h28;
  localparam logic [7:0] OFS_BIN_LO_TOP = 8'h2c;
  localparam logic [7:0] OFS_LAST       = OFS_BIN_LO_TOP;

  // control field positions
  localparam int CTRL_START    = 0;
  localparam int CTRL_OP_LSB   = 1;
  localparam int CTRL_CODE_LSB = 3;
  localparam int CTRL_COND_LSB = 12;
  localparam int CTRL_LEAD     = 15;
  localparam int CTRL_HALT     = 16;

  // status field positions
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_SKIP    = 2;
  localparam int ST_BADCODE = 3;
  localparam int ST_NONZERO = 4;
  localparam int ST_MINUS   = 5;
  localparam int ST_HALTED  = 6;

  // widths and counts
  localparam int LEN_W  = 27;
  localparam int WORD_W = 36;
  localparam int BIN_W  = 71;
  localparam int DIG_W  = 5;
  localparam int DIG_MAX = 22;
  localparam logic [6:0] DIV_LAST = 7'h46;

  // extension operation code (octal 123)
  localparam logic [8:0] EXT_CODE = 9'h053;

  // reset values
  localparam logic [LEN_W-1:0] LEN_RST  = 27'h0;
  localparam logic [31:0]      PTR_RST  = 32'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 36'h0;

  typedef enum logic [1:0] {
    op_move_right_justified = 2'h0,
    op_compare_strings      = 2'h1,
    op_bin_to_dec_offset    = 2'h2,
    op_bin_to_dec_translate = 2'h3
  } op_t;

  typedef enum logic [2:0] {
    compare_skip_less          = 3'h1,
    compare_skip_equal         = 3'h2,
    compare_skip_less_equal    = 3'h3,
    compare_skip_greater_equal = 3'h5,
    compare_skip_not_equal     = 3'h6,
    compare_skip_greater       = 3'h7
  } cond_t;

endpackage

/* verilog/digit_store.sv */
module digit_store
#(
  parameter int WIDTH = 4,
  parameter int DEPTH = 22,
  parameter int AW    = 5
)
(
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end

endmodule

/* verilog/string_move_compare_convert.sv */
// The placing of the registers and the APB register port were decided locally.
module string_move_compare_convert
  import strop_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // byte memory port
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output logic      [31:0] MEM_ADDR,
  output logic      [7:0]  MEM_WDATA,
  input  wire logic [7:0]  MEM_RDATA,
  input  wire logic        MEM_ACK,
  // sequencer
  output logic             BUSY,
  output logic             DONE,
  output logic             SKIP
);

  typedef enum logic [10:0] {
    S_IDLE = 11'h001,
    S_PREP = 11'h002,
    S_FILL = 11'h004,
    S_RDA  = 11'h008,
    S_RDB  = 11'h010,
    S_WR   = 11'h020,
    S_DIV  = 11'h040,
    S_DCHK = 11'h080,
    S_DRD  = 11'h100,
    S_XL   = 11'h200,
    S_END  = 11'h400
  } state_t;

  function automatic logic mapped(input logic [7:0] a);
    return (a <= OFS_LAST) && (a[1:0] == 2'h0);
  endfunction

  state_t              state;
  op_t                 op;
  logic [8:0]          code;
  logic [2:0]          cond;
  logic                lead_fill;
  logic                halt_req;
  logic [LEN_W-1:0]    src_len;
  logic [LEN_W-1:0]    dst_len;
  logic [31:0]         src_ptr;
  logic [31:0]         dst_ptr;
  logic [7:0]          fill1;
  logic [7:0]          fill2;
  logic [17:0]         opnd;
  logic [WORD_W-1:0]   bin_hi;
  logic [WORD_W-1:0]   bin_lo;
  logic                done;
  logic                skip;
  logic                bad_code;
  logic                flag_n;
  logic                flag_m;
  logic                halted;
  logic                done_pulse;
  logic [7:0]          byte_a;
  logic [LEN_W-1:0]    disc;
  logic [BIN_W-1:0]    q;
  logic [3:0]          rem;
  logic [6:0]          cnt;
  logic [DIG_W-1:0]    ndig;
  logic                neg;
  logic                lt;
  logic                gt;
  logic [3:0]          dig_rd;

  // bus decode
  wire apb_wr    = PSEL & PENABLE & PWRITE & mapped(PADDR);
  wire busy      = (state != S_IDLE);
  wire start_req = apb_wr & (PADDR == OFS_CTRL) & PWDATA[CTRL_START] & ~busy;
  wire [8:0] start_code = PWDATA[CTRL_CODE_LSB +: 9];

  // operation class
  wire is_move = (op == op_move_right_justified);
  wire is_cmp  = (op == op_compare_strings);
  wire is_cvt  = op[1];
  wire is_xlat = (op == op_bin_to_dec_translate);

  // binary operand: sign in top bit of high word, low top bit unused
  wire [BIN_W-1:0] bin_val = {bin_hi, bin_lo[34:0]};
  wire [BIN_W-1:0] mag     = bin_hi[35] ? (~bin_val + 71'h1) : bin_val;

  // one quotient bit per cycle of divide by ten
  wire [4:0]       trial    = {rem, q[BIN_W-1]};
  wire             q_bit    = (trial >= 5'h0a);
  wire [3:0]       next_rem = q_bit ? 4'(trial - 5'h0a) : trial[3:0];
  wire [BIN_W-1:0] next_q   = {q[BIN_W-2:0], q_bit};
  wire             dig_wr   = (state == S_DIV) && (cnt == DIV_LAST);

  // fill stops when remaining places just fit the payload
  wire [LEN_W-1:0] ndig_len   = {{(LEN_W-DIG_W){1'b0}}, ndig};
  wire [LEN_W-1:0] fill_floor = is_move ? src_len : ndig_len;
  wire [LEN_W-1:0] dst_dec    = dst_len - 27'h1;
  wire [LEN_W-1:0] dst_after  = (dst_len != LEN_RST) ? dst_dec : LEN_RST;

  // compare operands; exhausted string takes its own fill
  wire a_live = (src_len != LEN_RST);
  wire b_live = (dst_len != LEN_RST);
  wire [7:0] byte_b = b_live ? MEM_RDATA : fill2;

  // final digit of a negative number uses the left half
  wire last_dig  = (ndig == 5'h01);
  wire use_left  = last_dig & flag_m;
  wire [31:0] xl_addr = {14'h0, opnd} + {27'h0, dig_rd, ~use_left};
  wire [17:0] off_sum = {14'h0, dig_rd} + opnd;

  wire [31:0] src_next = src_ptr + 32'h1;
  wire [31:0] dst_next = dst_ptr + 32'h1;

  wire st_fill = (state == S_FILL);
  wire st_rda  = (state == S_RDA);
  wire st_rdb  = (state == S_RDB);
  wire st_wr   = (state == S_WR);
  wire st_xl   = (state == S_XL);

  wire step_a = st_rda & (~a_live | MEM_ACK);
  wire step_b = st_rdb & (~b_live | MEM_ACK);
  wire cmp_ne = (byte_a != byte_b);

  // unsigned byte ordering and condition decode
  wire cond_hit = cond[2] ^ ((cond[0] & lt) | (cond[1] & ~lt & ~gt));

  assign MEM_REQ = st_fill | st_wr | st_xl | (st_rda & a_live)
                 | (st_rdb & b_live);
  assign MEM_WE  = st_fill | st_wr;
  assign MEM_ADDR = st_rda ? src_next : (st_xl ? xl_addr : dst_next);
  assign MEM_WDATA = st_fill ? fill1
                   : ((is_cvt & ~is_xlat) ? off_sum[7:0] : byte_a);
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped(PADDR);
  assign BUSY    = busy;
  assign DONE    = done_pulse;
  assign SKIP    = skip;

  digit_store #(.WIDTH(4), .DEPTH(DIG_MAX), .AW(DIG_W)) u_digits
  (
    .clk     (CLK),
    .wr_en   (dig_wr),
    .wr_addr (ndig),
    .wr_data (next_rem),
    .rd_addr (ndig - 5'h01),
    .rd_data (dig_rd)
  );

  // read data registered in the setup phase, so no wait state needed
  always_ff @(posedge CLK)
  begin
    if (RST)
      PRDATA <= 32'h0;
    else if (PSEL & ~PENABLE)
    begin
      case (PADDR)
        OFS_CTRL:       PRDATA <= {15'h0, halt_req, lead_fill, cond, code,
                                   op, 1'b0};
        OFS_STATUS:     PRDATA <= {25'h0, halted, flag_m, flag_n, bad_code,
                                   skip, done, busy};
        OFS_SRC_LEN:    PRDATA <= {5'h0, src_len};
        OFS_SRC_PTR:    PRDATA <= src_ptr;
        OFS_DST_LEN:    PRDATA <= {5'h0, dst_len};
        OFS_DST_PTR:    PRDATA <= dst_ptr;
        OFS_FILL:       PRDATA <= {16'h0, fill2, fill1};
        OFS_OPERAND:    PRDATA <= {14'h0, opnd};
        OFS_BIN_HI:     PRDATA <= bin_hi[31:0];
        OFS_BIN_HI_TOP: PRDATA <= {28'h0, bin_hi[35:32]};
        OFS_BIN_LO:     PRDATA <= bin_lo[31:0];
        OFS_BIN_LO_TOP: PRDATA <= {28'h0, bin_lo[35:32]};
        default:        PRDATA <= 32'h0;
      endcase
    end
  end

  // operands are frozen while busy; only halt and the status flag clear get through
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state <= S_IDLE;
      op <= op_move_right_justified;
      code <= 9'h0;
      cond <= 3'h0;
      lead_fill <= 1'b0;
      halt_req <= 1'b0;
      src_len <= LEN_RST;
      dst_len <= LEN_RST;
      src_ptr <= PTR_RST;
      dst_ptr <= PTR_RST;
      fill1 <= 8'h0;
      fill2 <= 8'h0;
      opnd <= 18'h0;
      bin_hi <= WORD_RST;
      bin_lo <= WORD_RST;
      done <= 1'b0;
      skip <= 1'b0;
      bad_code <= 1'b0;
      flag_n <= 1'b0;
      flag_m <= 1'b0;
      halted <= 1'b0;
      done_pulse <= 1'b0;
      byte_a <= 8'h0;
      disc <= LEN_RST;
      q <= 71'h0;
      rem <= 4'h0;
      cnt <= 7'h0;
      ndig <= 5'h0;
      neg <= 1'b0;
      lt <= 1'b0;
      gt <= 1'b0;
    end
    else
    begin
      done_pulse <= 1'b0;
      if (apb_wr)
      begin
        case (PADDR)
          OFS_CTRL:
          begin
            halt_req <= PWDATA[CTRL_HALT] & busy;
            if (!busy)
            begin
              op <= op_t'(PWDATA[CTRL_OP_LSB +: 2]);
              code <= start_code;
              cond <= PWDATA[CTRL_COND_LSB +: 3];
              lead_fill <= PWDATA[CTRL_LEAD];
            end
          end
          OFS_STATUS:
          begin
            flag_n <= 1'b0;
            flag_m <= 1'b0;
          end
          OFS_SRC_LEN:    if (!busy) src_len <= PWDATA[LEN_W-1:0];
          OFS_SRC_PTR:    if (!busy) src_ptr <= PWDATA;
          OFS_DST_LEN:    if (!busy) dst_len <= PWDATA[LEN_W-1:0];
          OFS_DST_PTR:    if (!busy) dst_ptr <= PWDATA;
          OFS_FILL:
          begin
            if (!busy)
            begin
              fill1 <= PWDATA[7:0];
              fill2 <= PWDATA[15:8];
            end
          end
          OFS_OPERAND:    if (!busy) opnd <= PWDATA[17:0];
          OFS_BIN_HI:     if (!busy) bin_hi[31:0] <= PWDATA;
          OFS_BIN_HI_TOP: if (!busy) bin_hi[35:32] <= PWDATA[3:0];
          OFS_BIN_LO:     if (!busy) bin_lo[31:0] <= PWDATA;
          OFS_BIN_LO_TOP: if (!busy) bin_lo[35:32] <= PWDATA[3:0];
          default: ;
        endcase
      end
      case (state)
        S_IDLE:
        begin
          if (start_req)
          begin
            done <= 1'b0;
            skip <= 1'b0;
            halted <= 1'b0;
            bad_code <= (start_code != EXT_CODE);
            if (start_code == EXT_CODE)
              state <= S_PREP;
          end
        end
        S_PREP:
        begin
          lt <= 1'b0;
          gt <= 1'b0;
          if (is_move && (src_len > dst_len))
          begin
            disc <= src_len - dst_len;
            src_ptr <= src_ptr + {5'h0, src_len - dst_len};
            src_len <= dst_len;
            state <= (dst_len == LEN_RST) ? S_END : S_RDA;
          end
          else if (is_move)
          begin
            disc <= LEN_RST;
            state <= (src_len < dst_len) ? S_FILL
                   : ((src_len == LEN_RST) ? S_END : S_RDA);
          end
          else if (is_cmp)
            state <= (a_live | b_live) ? S_RDA : S_END;
          else
          begin
            q <= mag;
            neg <= bin_hi[35];
            rem <= 4'h0;
            cnt <= 7'h0;
            ndig <= 5'h0;
            state <= S_DIV;
          end
        end
        S_FILL:
        begin
          if (MEM_ACK)
          begin
            dst_ptr <= dst_next;
            dst_len <= dst_dec;
            if (dst_dec == fill_floor)
            begin
              if (is_cvt)
                state <= S_DRD;
              else
                state <= (src_len == LEN_RST) ? S_END : S_RDA;
            end
            else if (halt_req && is_move)
            begin
              halted <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        S_RDA:
        begin
          if (step_a)
          begin
            byte_a <= a_live ? MEM_RDATA : fill1;
            if (a_live)
            begin
              src_ptr <= src_next;
              src_len <= src_len - 27'h1;
            end
            state <= is_cmp ? S_RDB : S_WR;
          end
        end
        S_RDB:
        begin
          if (step_b)
          begin
            dst_len <= dst_after;
            if (b_live)
              dst_ptr <= dst_next;
            if (cmp_ne)
            begin
              lt <= (byte_a < byte_b);
              gt <= (byte_a > byte_b);
              state <= S_END;
            end
            else if (!a_live && dst_after == LEN_RST)
              state <= S_END;
            else if (halt_req)
            begin
              halted <= 1'b1;
              state <= S_IDLE;
            end
            else
              state <= S_RDA;
          end
        end
        S_WR:
        begin
          if (MEM_ACK)
          begin
            dst_ptr <= dst_next;
            dst_len <= dst_dec;
            if (is_cvt)
            begin
              ndig <= ndig - 5'h01;
              state <= last_dig ? S_END : S_DRD;
            end
            else if (src_len == LEN_RST)
              state <= S_END;
            else if (halt_req)
            begin
              halted <= 1'b1;
              state <= S_IDLE;
            end
            else
              state <= S_RDA;
          end
        end
        S_DIV:
        begin
          q <= next_q;
          if (cnt == DIV_LAST)
          begin
            rem <= 4'h0;
            cnt <= 7'h0;
            ndig <= ndig + 5'h01;
            if (next_q == 71'h0)
              state <= S_DCHK;
          end
          else
          begin
            rem <= next_rem;
            cnt <= cnt + 7'h01;
          end
        end
        S_DCHK:
        begin
          if (ndig_len > dst_len)
          begin
            done <= 1'b1;
            done_pulse <= 1'b1;
            state <= S_IDLE;
          end
          else
          begin
            flag_n <= (mag != 71'h0);
            flag_m <= neg;
            state <= (lead_fill && dst_len > ndig_len) ? S_FILL
                     : S_DRD;
          end
        end
        S_DRD:
          state <= is_xlat ? S_XL : S_WR;
        S_XL:
        begin
          if (MEM_ACK)
          begin
            byte_a <= MEM_RDATA;
            state <= S_WR;
          end
        end
        S_END:
        begin
          skip <= is_cmp ? cond_hit : 1'b1;
          if (is_move)
            src_len <= disc;
          if (is_cvt)
          begin
            bin_hi <= WORD_RST;
            bin_lo <= WORD_RST;
            dst_len <= LEN_RST;
          end
          done <= 1'b1;
          done_pulse <= 1'b1;
          state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_div_start;
    (state == S_DIV) && (cnt == 7'h00) && (ndig == 5'h00);
  endsequence
  sequence s_first_digit;
    ##70 dig_wr;
  endsequence

  property p_bad_code;
    start_req && (start_code != EXT_CODE) |=> bad_code && !busy;
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("wrong extension code started a run");

  property p_move_skip;
    done_pulse && is_move |-> skip && (dst_len == 27'h0);
  endproperty
  a_move_skip: assert property (p_move_skip)
    else $error("move ended without skip or with length left");

  property p_fill_byte;
    st_fill |-> MEM_WE && (MEM_WDATA == fill1) && (dst_len > fill_floor);
  endproperty
  a_fill_byte: assert property (p_fill_byte)
    else $error("bad fill write");

  property p_dest_only;
    MEM_WE |-> (MEM_ADDR == dst_ptr + 32'h1);
  endproperty
  a_dest_only: assert property (p_dest_only)
    else $error("write outside destination");

  property p_cmp_read_only;
    busy && is_cmp |-> !MEM_WE;
  endproperty
  a_cmp_read_only: assert property (p_cmp_read_only)
    else $error("compare wrote memory");

  property p_cmp_stop;
    step_b && cmp_ne |=> (state == S_END) ##1 (done_pulse && !busy);
  endproperty
  a_cmp_stop: assert property (p_cmp_stop)
    else $error("compare ran past unequal pair");

  property p_too_long;
    (state == S_DCHK) && (ndig_len > dst_len)
      |=> done_pulse && !skip && $stable(bin_hi) && $stable(dst_len);
  endproperty
  a_too_long: assert property (p_too_long)
    else $error("oversize conversion changed state or skipped");

  property p_cvt_clear;
    done_pulse && is_cvt && skip |-> (bin_hi == 36'h0) && (bin_lo == 36'h0)
                                      && (dst_len == 27'h0);
  endproperty
  a_cvt_clear: assert property (p_cvt_clear)
    else $error("conversion left binary or length");

  property p_digit_time;
    s_div_start |-> s_first_digit;
  endproperty
  a_digit_time: assert property (p_digit_time)
    else $error("digit not ready after 71 cycles");

endmodule

/* verif/mem_model.sv */
module mem_model (
  // byte bus
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  output logic             ack,
  // reply speed
  input  wire logic [1:0]  lat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [1:0] wait_cnt = 2'h0;
  logic [7:0] last     = 8'h00;
  // slow replies stretch each byte by lat cycles
  assign ack = req && (wait_cnt == lat);
  // off an ack the lines show junk, never the last byte
  assign rdata = ack ? mem[addr[7:0]] : ~last;
  always @(posedge clk)
  begin
    wait_cnt <= (req && !ack) ? wait_cnt + 2'h1 : 2'h0;
    if (ack)
    begin
      last <= rdata;
      if (we)
        mem[addr[7:0]] <= wdata;
    end
  end
endmodule

/* verif/tb_top.sv */
module tb_top;
  import strop_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, mreq, mwe, mack;
  logic        busy, done, skip, err;
  logic [7:0]  paddr = 8'h00, mwd, mrd;
  logic [31:0] pwdata = 32'h0, prdata, q, maddr;
  logic [1:0]  lat = 2'h0;
  int          mismatches = 0, num_checks = 0;
  always #50 clk = ~clk;
  string_move_compare_convert i_string_move_compare_convert (.CLK(clk),
    .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MEM_REQ(mreq), .MEM_WE(mwe), .MEM_ADDR(maddr),
    .MEM_WDATA(mwd), .MEM_RDATA(mrd), .MEM_ACK(mack), .BUSY(busy),
    .DONE(done), .SKIP(skip));
  mem_model i_mem_model (.clk(clk), .req(mreq), .we(mwe), .addr(maddr),
    .wdata(mwd), .rdata(mrd), .ack(mack), .lat(lat));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer; q and err taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string m);
    apb(1'b0, a, 32'h0);
    chk(q, e, m);
  endtask
  task automatic go(input logic [1:0] op, input logic [2:0] c,
                    input logic l, input logic [31:0] sl, sp, dl, dp,
                    input logic [15:0] f, input logic [17:0] o);
    apb(1'b1, OFS_SRC_LEN, sl);
    apb(1'b1, OFS_SRC_PTR, sp);
    apb(1'b1, OFS_DST_LEN, dl);
    apb(1'b1, OFS_DST_PTR, dp);
    apb(1'b1, OFS_FILL, {16'h0, f});
    apb(1'b1, OFS_OPERAND, {14'h0, o});
    run({16'h0, l, c, EXT_CODE, op, 1'b1});
  endtask
  // start a run and wait for its done pulse
  task automatic run(input logic [31:0] c);
    apb(1'b1, OFS_CTRL, c);
    for (int i = 0; i < 4000 && done !== 1'b1; i++)
      @(posedge clk);
    chk({31'h0, done}, 32'h1, "no done");
  endtask
  task automatic bin(input logic [31:0] hi, lo, input logic [3:0] ht, lt);
    apb(1'b1, OFS_BIN_HI, hi);
    apb(1'b1, OFS_BIN_HI_TOP, {28'h0, ht});
    apb(1'b1, OFS_BIN_LO, lo);
    apb(1'b1, OFS_BIN_LO_TOP, {28'h0, lt});
    apb(1'b1, OFS_STATUS, 32'h0);
  endtask
  task automatic test_move;
    int sl[3] = '{3, 2, 4};
    int dl[3] = '{3, 4, 2};
    int k;
    for (int n = 0; n < 3; n++)
    begin
      lat <= n[1:0];
      go(op_move_right_justified, 3'h0, 1'b0, sl[n], 32'h0f, dl[n],
         32'h3f + 16 * n, 16'h2a, 18'h0);
      chk(skip, 1, "move skip");
      for (int j = 0; j < dl[n]; j++)
      begin
        k = j + sl[n] - dl[n];
        chk(i_mem_model.mem[8'h40 + 16 * n + j],
            k < 0 ? 8'h2a : 8'h10 + k[7:0], "move byte");
      end
      rd(OFS_SRC_LEN, sl[n] > dl[n] ? sl[n] - dl[n] : 0, "sl");
      rd(OFS_DST_LEN, 0, "dl");
      rd(OFS_DST_PTR, 32'h3f + 16 * n + dl[n], "dp");
      rd(OFS_SRC_PTR, 32'h0f + sl[n], "sp");
    end
    for (int j = 0; j < 4; j++)
      chk(i_mem_model.mem[8'h10 + j], 8'h10 + j, "source");
    lat <= 2'h0;
    $display("test move done");
  endtask
  task automatic test_compare;
    logic [7:0] m81[4] = '{8'h42, 8'h41, 8'h42, 8'hc2};
    logic [7:0] f2[4]  = '{8'h43, 8'h43, 8'h00, 8'h43};
    int         rel[4] = '{0, 1, 2, 2};
    int         rem[4] = '{0, 1, 0, 1};
    logic [2:0] cs[6]  = '{1, 2, 3, 5, 6, 7};
    logic       e;
    // string 1 is 41 m81 43, string 2 is 41 42 then its fill
    i_mem_model.mem[8'h80] = 8'h41;
    i_mem_model.mem[8'h82] = 8'h43;
    i_mem_model.mem[8'h90] = 8'h41;
    i_mem_model.mem[8'h91] = 8'h42;
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 6; c++)
      begin
        i_mem_model.mem[8'h81] = m81[r];
        go(op_compare_strings, cs[c], 1'b0, 3, 32'h7f, 2, 32'h8f,
           {f2[r], 8'h00}, 18'h0);
        e = (rel[r] == 1) ? (cs[c] inside {3'h1, 3'h3, 3'h6})
          : (rel[r] == 0) ? (cs[c] inside {3'h2, 3'h3, 3'h5})
          : (cs[c] inside {3'h5, 3'h6, 3'h7});
        chk(skip, e, "cmp skip");
        rd(OFS_SRC_LEN, rem[r], "cmp sl");
        rd(OFS_DST_LEN, 0, "cmp dl");
        rd(OFS_SRC_PTR, 32'h82 - rem[r], "cmp sp");
        rd(OFS_DST_PTR, 32'h91, "cmp dp");
      end
    chk(i_mem_model.mem[8'h91], 8'h42, "cmp wrote");
    $display("test compare done");
  endtask
  task automatic test_convert;
    string s = "  1180591620717411303423";
    // low word top bit set although sign is clear: must be ignored
    bin(32'hffffffff, 32'hffffffff, 4'h7, 4'hf);
    go(op_bin_to_dec_offset, 3'h0, 1'b1, 0, 0, 21, 32'hbf, 16'h20, 18'h30);
    chk(skip, 0, "short skip");
    rd(OFS_DST_LEN, 21, "short dl");
    rd(OFS_BIN_LO, 32'hffffffff, "short bin");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q[5:4], 2'b00, "short flags");
    chk(i_mem_model.mem[8'hc0], 8'hc0, "short mem");
    go(op_bin_to_dec_offset, 3'h0, 1'b1, 0, 0, 24, 32'hbf, 16'h20, 18'h30);
    chk(skip, 1, "cvt skip");
    for (int j = 0; j < 24; j++)
      chk(i_mem_model.mem[8'hc0 + j], s[j], "digit");
    rd(OFS_DST_LEN, 0, "cvt dl");
    rd(OFS_DST_PTR, 32'hd7, "cvt dp");
    rd(OFS_BIN_HI, 0, "cvt hi");
    rd(OFS_BIN_LO, 0, "cvt lo");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q[5:4], 2'b01, "cvt flags");
    bin(32'hffffffff, 32'hfffffff9, 4'hf, 4'h7);
    go(op_bin_to_dec_translate, 3'h0, 1'b0, 0, 0, 1, 32'hdf, 16'h0,
       18'ha0);
    chk(i_mem_model.mem[8'he0], 8'h77, "last digit");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q[5:4], 2'b11, "neg flags");
    $display("test convert done");
  endtask
  task automatic test_halt;
    logic [31:0] st = {20'h0, EXT_CODE, op_move_right_justified, 1'b1};
    // slow memory so the halt lands while the first byte is in flight
    lat <= 2'h2;
    apb(1'b1, OFS_SRC_LEN, 32'h4);
    apb(1'b1, OFS_SRC_PTR, 32'h0f);
    apb(1'b1, OFS_DST_LEN, 32'h4);
    apb(1'b1, OFS_DST_PTR, 32'hef);
    apb(1'b1, OFS_CTRL, st);
    apb(1'b1, OFS_CTRL, 32'h10000);
    for (int i = 0; i < 100 && busy !== 1'b0; i++)
      @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({30'h0, q[ST_HALTED], q[ST_DONE]}, 32'h2, "halt status");
    rd(OFS_SRC_LEN, 3, "halt sl");
    rd(OFS_DST_LEN, 3, "halt dl");
    run(st);
    chk(skip, 1, "resumed skip");
    for (int j = 0; j < 4; j++)
      chk(i_mem_model.mem[8'hf0 + j], 8'h10 + j, "resumed byte");
    lat <= 2'h0;
    $display("test halt done");
  endtask
  task automatic test_refuse;
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (3)
      @(posedge clk);
    chk(busy, 0, "bad code ran");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q[ST_BADCODE], 1, "bad code flag");
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped err");
    chk(q, 32'h0, "unmapped data");
    $display("test refuse done");
  endtask
  initial
  begin
    for (int i = 0; i < 256; i++)
      i_mem_model.mem[i] = i[7:0];
    for (int d = 0; d < 10; d++)
    begin
      i_mem_model.mem[8'ha0 + 2 * d] = 8'h70 + d;
      i_mem_model.mem[8'ha1 + 2 * d] = 8'h60 + d;
    end
    repeat (5)
      @(posedge clk);
    rst <= 1'b0;
    test_move;
    test_compare;
    test_convert;
    test_halt;
    test_refuse;
    tally_and_finish;
  end
  // whole run is a few thousand cycles
  initial
  begin
    repeat (90000)
      @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
endmodule
